// File: rtl/prc_regs.svh
/*
  Named constants of the power and reset control block: bit positions
  of the two power control registers and the memory map register,
  reset values and timing counts.
  Assumes a 100 MHz core clock; included by its bare name.
*/
`ifndef PRC_REGS_SVH
`define PRC_REGS_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define PRC_CLK_PERIOD_NS  10
`define PRC_POST_RESET_NS  120
`define PRC_POST_RESET_CYC (`PRC_POST_RESET_NS / `PRC_CLK_PERIOD_NS)
`define PRC_ABORT_US       25
`define PRC_ABORT_CYC      ((`PRC_ABORT_US * 1000) / `PRC_CLK_PERIOD_NS)
`define PRC_PWRUP_RST_MS   1
`define PRC_WARM_RST_NS    150
`define PRC_CFG_LOAD_CYC   3'h4
`define PRC_APD_LIMIT      4'hf

// ----------------------------------------------------------------
// Register fields and reset values
// ----------------------------------------------------------------
`define PRC_P0_ANDCLK  4
`define PRC_P0_MCCLK   5
`define PRC_P2_ADDR    0
`define PRC_P2_CTRL0   2
`define PRC_P2_CTRL1   3
`define PRC_P2_CTRL2   4
`define PRC_P2_STROBE  5
`define PRC_P2_BYTEEN  6
`define PRC_MM_CODE    0
`define PRC_MM_PERIPH  7
`define PRC_MM_DEFAULT 8'h0d
`define PRC_MM_RST_VAL (`PRC_MM_DEFAULT & 8'h7e)
`define PRC_REG_CLEAR  8'h00
`define PRC_CNT_CLEAR  4'h0

`endif

// File: rtl/prc_pkg.sv
/*
  Types of the power and reset control block: flash sequencer states
  and the packed state records of both modules.
  Assumes prc_regs.svh for the numeric constants.
*/
package prc_pkg;

  // ----------------------------------------------------------------
  // Flash sequencer
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PRC_FL_READ,
    PRC_FL_PROG,
    PRC_FL_ERASE
  } prc_flash_t;

  // ----------------------------------------------------------------
  // State records
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0] cnt;
    logic       flag;
    logic       strobe_prev;
    logic       clk_prev;
  } prc_apd_state_t;

  typedef struct packed {
    logic [7:0] pmr0;
    logic [7:0] pmr2;
    logic [7:0] mmap;
    logic       por_phase;
    logic       in_reset;
    logic [3:0] dly;
    logic [2:0] cfg_cnt;
    logic       cfg_valid;
    prc_flash_t flash;
    logic       busy;
    logic       abort;
    logic       pclk_prev;
    logic [7:0] mcell;
    logic [7:0] pld_addr;
    logic [2:0] pld_ctrl;
    logic       pld_strobe;
    logic       pld_byte_en;
    logic       pld_and_clk;
    logic       pld_mc_clk;
    logic       mem_en;
    logic       io_en;
    logic       gpio_oe_n;
    logic       addr_oe_n;
    logic       data_oe_n;
    logic       periph_oe_n;
  } prc_top_state_t;

endpackage

// File: rtl/prc_apd_counter.sv
/*
  Automatic power-down counter: watches the address strobe and counts
  sampled rising edges of the PLD clock input while the strobe is idle.
  Assumes all inputs synchronous to core_clk.
*/
`timescale 1ns/100ps
`include "prc_regs.svh"

module prc_apd_counter
  import prc_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       clear,
  input  wire logic       enable,
  input  wire logic       polarity,
  input  wire logic       addr_strobe,
  input  wire logic       pld_clock_in,
  output logic            powerdown_flag
);

  prc_apd_state_t st_r;
  prc_apd_state_t st_nxt;
  logic           edge_seen;
  logic           clk_rise;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  assign edge_seen = addr_strobe != st_r.strobe_prev;
  assign clk_rise  = pld_clock_in && !st_r.clk_prev;

  // Blocking of the clock toward the PLD never reaches this counter
  always_comb begin
    st_nxt             = st_r;
    st_nxt.strobe_prev = addr_strobe;
    st_nxt.clk_prev    = pld_clock_in;
    if (clear || !enable) begin
      st_nxt.cnt  = `PRC_CNT_CLEAR;
      st_nxt.flag = 1'b0;
    end else if (edge_seen) begin
      st_nxt.cnt  = `PRC_CNT_CLEAR;
      st_nxt.flag = 1'b0;
    end else if (addr_strobe == polarity && clk_rise &&
                 st_r.cnt != `PRC_APD_LIMIT) begin
      st_nxt.cnt = st_r.cnt + 4'h1;
      if (st_nxt.cnt == `PRC_APD_LIMIT) begin
        st_nxt.flag = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign powerdown_flag = st_r.flag;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_apd_idle: assert property (
    @(posedge core_clk) disable iff (rst)
    !enable |=> st_r.cnt == 4'h0 && !powerdown_flag)
    else $error("apd counter moved while disabled");

  chk_apd_flag_cnt: assert property (
    @(posedge core_clk) disable iff (rst)
    $rose(powerdown_flag) |-> st_r.cnt == 4'hf && $past(st_r.cnt) == 4'he)
    else $error("power-down flag not at fifteen counts");

  chk_apd_edge_clr: assert property (
    @(posedge core_clk) disable iff (rst)
    (addr_strobe != st_r.strobe_prev) |=> st_r.cnt == 4'h0)
    else $error("strobe edge did not clear counter");

  chk_apd_wake: assert property (
    @(posedge core_clk) disable iff (rst)
    powerdown_flag && (addr_strobe != st_r.strobe_prev) |=> !powerdown_flag)
    else $error("strobe pulse did not end power-down");

  cov_apd_enter: cover property (
    @(posedge core_clk) disable iff (rst) $rose(powerdown_flag));

endmodule

// File: rtl/prc_top.sv
/*
  Power and reset control: memory select gating, PLD input blocking,
  automatic power-down, reset sequencing, flash abort and port states.
  Assumes synchronous inputs at 100 MHz; rst is the internal power-on
  reset, reset_n the sampled external reset pin.
*/
`timescale 1ns/100ps
`include "prc_regs.svh"

// Summary of operation
// - Select low enables flashes, SRAM and I/O
// - Select high powers memories down, PLD stays
// - Control bits 4/5 block PLD clock
// - Second register bits block PLD inputs
// - Counter idle when disabled or strobe pulsing
// - Steady strobe counts fifteen clocks, flag rises
// - Power-up loads configuration, clears power control registers
// - Stay in reset 120 ns after release
// - Flash sequencer starts in read mode
// - No flash write start under supply lockout
// - Warm reset has same post-reset delay
// - PLD outputs valid in warm reset, after load
// - Power-down PLD runs with address blocked
// - Reset aborts program or erase to read
// - Port pins take defined reset/power-down states
// - Control registers clear on power-up only
// - Macrocells clear at power-up, else equations
// - Reset reloads memory map, forced bits zero
// - Strobe, select or reset ends power-down
// - Power-down blocks bus and deselects memories
module prc_top
  import prc_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       reset_n,
  input  wire logic       select_n,
  input  wire logic       addr_strobe,
  input  wire logic       strobe_polarity,
  input  wire logic       apd_enable,
  input  wire logic       pld_clock_in,
  input  wire logic [7:0] addr_lo_in,
  input  wire logic       ctrl_in0,
  input  wire logic       ctrl_in1,
  input  wire logic       ctrl_in2,
  input  wire logic       byte_enable_in,
  input  wire logic       pmr0_wr,
  input  wire logic       pmr2_wr,
  input  wire logic       mmap_wr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       lockout_voltage,
  input  wire logic       flash_prog_start,
  input  wire logic       flash_erase_start,
  input  wire logic       flash_op_done,
  input  wire logic [7:0] mcell_d,
  input  wire logic [7:0] mcell_re,
  input  wire logic [7:0] mcell_pr,
  input  wire logic       gpio_drive_req,
  input  wire logic       addr_out_req,
  input  wire logic       data_drive_req,
  input  wire logic       periph_drive_req,
  output logic            powerdown_flag,
  output logic            device_in_reset,
  output logic            pld_out_valid,
  output logic [7:0]      power_ctrl_reg0,
  output logic [7:0]      power_ctrl_reg2,
  output logic [7:0]      memory_map_reg,
  output logic            sram_code_bit,
  output logic            peripheral_mode_bit,
  output logic [7:0]      pld_addr_lo,
  output logic            pld_ctrl0,
  output logic            pld_ctrl1,
  output logic            pld_ctrl2,
  output logic            pld_strobe,
  output logic            pld_byte_en,
  output logic            pld_and_clk,
  output logic            pld_mcell_clk,
  output logic [7:0]      output_macrocell,
  output logic            primary_flash_en,
  output logic            secondary_flash_en,
  output logic            sram_en,
  output logic            io_en,
  output logic            flash_busy,
  output logic            flash_abort,
  output logic            gpio_oe_n,
  output logic            addr_out_oe_n,
  output logic            data_oe_n,
  output logic            periph_oe_n
);

  prc_top_state_t st_r;
  prc_top_state_t st_nxt;
  logic           warm_low;
  logic           rst_any;
  logic           pd;
  logic           apd_clear;
  logic           reg_wr_ok;
  logic           start_ok;
  logic           pclk_rise;

  // ----------------------------------------------------------------
  // Power-down counter
  // ----------------------------------------------------------------
  // Select low or any reset holds the counter cleared, ending power-down
  assign apd_clear = !select_n || warm_low || st_r.in_reset;

  prc_apd_counter u_apd (
    .core_clk       (core_clk),
    .rst            (rst),
    .clear          (apd_clear),
    .enable         (apd_enable),
    .polarity       (strobe_polarity),
    .addr_strobe    (addr_strobe),
    .pld_clock_in   (pld_clock_in),
    .powerdown_flag (powerdown_flag)
  );

  // ----------------------------------------------------------------
  // Shared terms
  // ----------------------------------------------------------------
  assign warm_low  = !reset_n;
  assign rst_any   = warm_low || st_r.in_reset;
  assign pd        = powerdown_flag;
  // Bus is blocked in power-down, so register writes are dropped then
  assign reg_wr_ok = !rst_any && !pd;
  assign start_ok  = !rst_any && !lockout_voltage && !pd;
  assign pclk_rise = pld_clock_in && !st_r.pclk_prev;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt           = st_r;
    st_nxt.pclk_prev = pld_clock_in;

    // Reset sequencing and post-reset delay
    if (warm_low) begin
      st_nxt.in_reset = 1'b1;
      st_nxt.dly      = `PRC_CNT_CLEAR;
    end else if (st_r.in_reset && st_r.cfg_valid) begin
      if (st_r.dly == 4'(`PRC_POST_RESET_CYC - 1)) begin
        st_nxt.in_reset  = 1'b0;
        st_nxt.por_phase = 1'b0;
      end else begin
        st_nxt.dly = st_r.dly + 4'h1;
      end
    end

    // Configuration load once after power-on
    if (!st_r.cfg_valid) begin
      st_nxt.cfg_cnt = st_r.cfg_cnt + 3'h1;
      if (st_nxt.cfg_cnt == `PRC_CFG_LOAD_CYC) begin
        st_nxt.cfg_valid = 1'b1;
      end
    end

    // Power control registers: warm reset leaves them alone
    if (st_r.por_phase && warm_low) begin
      st_nxt.pmr0 = `PRC_REG_CLEAR;
      st_nxt.pmr2 = `PRC_REG_CLEAR;
    end else if (reg_wr_ok) begin
      if (pmr0_wr) begin
        st_nxt.pmr0 = reg_wdata;
      end
      if (pmr2_wr) begin
        st_nxt.pmr2 = reg_wdata;
      end
    end

    // Memory map register reloads on either reset
    if (warm_low) begin
      st_nxt.mmap = `PRC_MM_RST_VAL;
    end else if (reg_wr_ok && mmap_wr) begin
      st_nxt.mmap = reg_wdata;
    end

    // Flash sequencer
    st_nxt.abort = warm_low && st_r.flash != PRC_FL_READ;
    unique case (st_r.flash)
      PRC_FL_READ: begin
        if (start_ok && flash_prog_start) begin
          st_nxt.flash = PRC_FL_PROG;
        end else if (start_ok && flash_erase_start) begin
          st_nxt.flash = PRC_FL_ERASE;
        end
      end
      PRC_FL_PROG, PRC_FL_ERASE: begin
        if (flash_op_done) begin
          st_nxt.flash = PRC_FL_READ;
        end
      end
      default: begin
        st_nxt.flash = PRC_FL_READ;
      end
    endcase
    // Abort is immediate, well inside the allowed window
    if (warm_low) begin
      st_nxt.flash = PRC_FL_READ;
    end
    st_nxt.busy = st_nxt.flash != PRC_FL_READ;

    // Macrocells follow their reset and preset terms at all times except power-on reset, which clears them
    for (int i = 0; i < 8; i++) begin
      if (mcell_pr[i]) begin
        st_nxt.mcell[i] = 1'b1;
      end else if (mcell_re[i]) begin
        st_nxt.mcell[i] = 1'b0;
      end else if (pclk_rise && !st_r.pmr0[`PRC_P0_MCCLK]) begin
        st_nxt.mcell[i] = mcell_d[i];
      end
    end

    // PLD input gating; address also blocked in power-down
    st_nxt.pld_and_clk = pld_clock_in &&
                         !st_r.pmr0[`PRC_P0_ANDCLK];
    st_nxt.pld_mc_clk  = pld_clock_in &&
                         !st_r.pmr0[`PRC_P0_MCCLK];
    if (st_r.pmr2[`PRC_P2_ADDR] || pd) begin
      st_nxt.pld_addr = `PRC_REG_CLEAR;
    end else begin
      st_nxt.pld_addr = addr_lo_in;
    end
    st_nxt.pld_ctrl[0] = ctrl_in0 && !st_r.pmr2[`PRC_P2_CTRL0];
    st_nxt.pld_ctrl[1] = ctrl_in1 && !st_r.pmr2[`PRC_P2_CTRL1];
    st_nxt.pld_ctrl[2] = ctrl_in2 && !st_r.pmr2[`PRC_P2_CTRL2];
    st_nxt.pld_strobe  = addr_strobe &&
                         !st_r.pmr2[`PRC_P2_STROBE];
    st_nxt.pld_byte_en = byte_enable_in &&
                         !st_r.pmr2[`PRC_P2_BYTEEN];

    // Memory selects; I/O ignores power-down, follows select and reset
    st_nxt.mem_en = !select_n && !pd && !rst_any;
    st_nxt.io_en  = !select_n && !rst_any;

    // Port drivers: inputs under reset; GPIO held, others released in power-down
    if (rst_any) begin
      st_nxt.gpio_oe_n = 1'b1;
    end else if (!pd) begin
      st_nxt.gpio_oe_n = !gpio_drive_req;
    end
    // Address out undefined in power-down: released to keep it safe
    st_nxt.addr_oe_n   = rst_any || pd || !addr_out_req;
    st_nxt.data_oe_n   = rst_any || pd || !data_drive_req;
    st_nxt.periph_oe_n = rst_any || pd || !periph_drive_req;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Power-on leaves the flash in read mode and macrocells cleared
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_r           <= '0;
      st_r.por_phase <= 1'b1;
      st_r.in_reset  <= 1'b1;
      st_r.mmap      <= `PRC_MM_RST_VAL;
      st_r.flash     <= PRC_FL_READ;
      st_r.gpio_oe_n <= 1'b1;
      st_r.addr_oe_n <= 1'b1;
      st_r.data_oe_n <= 1'b1;
      st_r.periph_oe_n <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign device_in_reset     = st_r.in_reset;
  assign pld_out_valid       = st_r.cfg_valid;
  assign power_ctrl_reg0     = st_r.pmr0;
  assign power_ctrl_reg2     = st_r.pmr2;
  assign memory_map_reg      = st_r.mmap;
  assign sram_code_bit       = st_r.mmap[`PRC_MM_CODE];
  assign peripheral_mode_bit = st_r.mmap[`PRC_MM_PERIPH];
  assign pld_addr_lo         = st_r.pld_addr;
  assign pld_ctrl0           = st_r.pld_ctrl[0];
  assign pld_ctrl1           = st_r.pld_ctrl[1];
  assign pld_ctrl2           = st_r.pld_ctrl[2];
  assign pld_strobe          = st_r.pld_strobe;
  assign pld_byte_en         = st_r.pld_byte_en;
  assign pld_and_clk         = st_r.pld_and_clk;
  assign pld_mcell_clk       = st_r.pld_mc_clk;
  assign output_macrocell    = st_r.mcell;
  assign primary_flash_en    = st_r.mem_en;
  assign secondary_flash_en  = st_r.mem_en;
  assign sram_en             = st_r.mem_en;
  assign io_en               = st_r.io_en;
  assign flash_busy          = st_r.busy;
  assign flash_abort         = st_r.abort;
  assign gpio_oe_n           = st_r.gpio_oe_n;
  assign addr_out_oe_n       = st_r.addr_oe_n;
  assign data_oe_n           = st_r.data_oe_n;
  assign periph_oe_n         = st_r.periph_oe_n;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_mem_desel: assert property (
    @(posedge core_clk) disable iff (rst)
    (select_n || pd) |=> !primary_flash_en && !sram_en && !secondary_flash_en)
    else $error("memories enabled while deselected");

  chk_mem_sel: assert property (
    @(posedge core_clk) disable iff (rst)
    !select_n && !pd && reset_n && !st_r.in_reset
    |=> primary_flash_en && io_en)
    else $error("memories not enabled while selected");

  chk_clk_block: assert property (
    @(posedge core_clk) disable iff (rst)
    st_r.pmr0[`PRC_P0_ANDCLK] |=> !pld_and_clk)
    else $error("blocked clock reached the and array");

  chk_addr_block: assert property (
    @(posedge core_clk) disable iff (rst)
    (st_r.pmr2[`PRC_P2_ADDR] || pd) |=> pld_addr_lo == 8'h00)
    else $error("blocked address reached the array");

  chk_pmr_warm: assert property (
    @(posedge core_clk) disable iff (rst)
    !st_r.por_phase && !reset_n |=> $stable(power_ctrl_reg0) &&
                                    $stable(power_ctrl_reg2))
    else $error("warm reset changed power control");

  chk_mmap_rst: assert property (
    @(posedge core_clk) disable iff (rst)
    !reset_n |=> !sram_code_bit && !peripheral_mode_bit &&
                 memory_map_reg == `PRC_MM_RST_VAL)
    else $error("memory map not reloaded on reset");

  chk_flash_lock: assert property (
    @(posedge core_clk) disable iff (rst)
    lockout_voltage && !flash_busy |=> !flash_busy)
    else $error("flash write started under lockout");

  chk_abort: assert property (
    @(posedge core_clk) disable iff (rst)
    !reset_n && flash_busy |=> !flash_busy && flash_abort)
    else $error("reset did not abort flash cycle");

  chk_post_delay: assert property (
    @(posedge core_clk) disable iff (rst)
    $rose(reset_n) && pld_out_valid |-> device_in_reset [*8]
    ##1 device_in_reset [*4] ##1 !device_in_reset)
    else $error("post-reset delay wrong");

  chk_port_rst: assert property (
    @(posedge core_clk) disable iff (rst)
    !reset_n |=> gpio_oe_n && addr_out_oe_n && data_oe_n && periph_oe_n)
    else $error("port driven during reset");

  chk_pld_valid: assert property (
    @(posedge core_clk) disable iff (rst)
    !reset_n && pld_out_valid |=> pld_out_valid)
    else $error("pld outputs dropped in warm reset");

  cov_abort: cover property (
    @(posedge core_clk) disable iff (rst) $rose(flash_abort));
  cov_warm_end: cover property (
    @(posedge core_clk) disable iff (rst) $fell(device_in_reset));
  cov_pd_select: cover property (
    @(posedge core_clk) disable iff (rst) pd ##1 !select_n ##1 !pd);

endmodule

// File: verification/prc_host_model.sv
/*
  Host side model: PLD clock source and external reset pin driver.
  Assumes core_clk at 100 MHz; requests come from the bench.
*/
`timescale 1ns/100ps

module prc_host_model #(
  parameter int PWRUP_CYC = 20,
  parameter int WARM_CYC  = 15
) (
  input  wire logic core_clk,
  input  wire logic clk_run,
  input  wire logic warm_req,
  output logic      pld_clock_in,
  output logic      reset_n
);
  int lo_cnt = PWRUP_CYC;

  initial {pld_clock_in, reset_n} = 2'h0;

  // PLD clock stands low unless asked to run; reset pin held low by count
  // Requests are read at the edge so they never race the bench's drive
  always @(posedge core_clk) begin
    pld_clock_in <= clk_run && !pld_clock_in;
    if (warm_req)
      lo_cnt <= WARM_CYC;
    else if (lo_cnt > 0)
      lo_cnt <= lo_cnt - 1;
    reset_n <= (lo_cnt == 0) && !warm_req;
  end
endmodule

// File: verification/prc_top_tb_top.sv
/*
  Self-checking bench of the power and reset control block.
  Assumes prc_top, prc_regs.svh and the host model beside it.
*/
`timescale 1ns/100ps
`include "prc_regs.svh"

module prc_top_tb_top;
  logic       core_clk, rst, reset_n, select_n, addr_strobe;
  logic       strobe_polarity, apd_enable, pld_clock_in, ctrl_in0;
  logic       ctrl_in1, ctrl_in2, byte_enable_in, pmr0_wr, pmr2_wr;
  logic       mmap_wr, lockout_voltage, flash_prog_start, flash_op_done;
  logic       flash_erase_start, gpio_drive_req, addr_out_req;
  logic       data_drive_req, periph_drive_req, clk_run, warm_req;
  logic [7:0] addr_lo_in, reg_wdata, mcell_d, mcell_re, mcell_pr;
  logic       powerdown_flag, device_in_reset, pld_out_valid;
  logic       sram_code_bit, peripheral_mode_bit, pld_ctrl0, pld_ctrl1;
  logic       pld_ctrl2, pld_strobe, pld_byte_en, pld_and_clk;
  logic       pld_mcell_clk, primary_flash_en, secondary_flash_en;
  logic       sram_en, io_en, flash_busy, flash_abort, gpio_oe_n;
  logic       addr_out_oe_n, data_oe_n, periph_oe_n;
  logic [7:0] power_ctrl_reg0, power_ctrl_reg2, memory_map_reg;
  logic [7:0] pld_addr_lo, output_macrocell;
  int         fails, checks;

  prc_top DUT (.*);
  prc_host_model #(.PWRUP_CYC(20), .WARM_CYC(15)) u_host (.*);

  always #5 core_clk = !core_clk;

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic chk(input string what, input logic [7:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Bounded wait; a hang ends the run at once
  task automatic wait_on(ref logic sig, input logic val, output int n);
    n = 0;
    while (sig !== val && n < 300) begin
      cyc(1);
      n++;
    end
    if (sig !== val) begin
      chk("wait", 8'h0, 8'h1);
      summarize();
    end
  endtask

  task automatic wr(input int which, input logic [7:0] d);
    reg_wdata = d;
    {pmr0_wr, pmr2_wr, mmap_wr} = 3'(3'h4 >> which);
    cyc(1);
    {pmr0_wr, pmr2_wr, mmap_wr} = 3'h0;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_select();
    select_n = 1'b0;
    addr_lo_in = 8'h5a;
    cyc(2);
    chk("mem_en", {primary_flash_en, secondary_flash_en, sram_en},
        8'h7);
    chk("io_en", io_en, 8'h1);
    select_n = 1'b1;
    cyc(2);
    chk("mem_off", {primary_flash_en, secondary_flash_en, sram_en},
        8'h0);
    chk("pld path", pld_addr_lo, 8'h5a);
  endtask

  task automatic t_block();
    logic [1:0] seen;
    clk_run = 1'b1;
    {ctrl_in0, ctrl_in1, ctrl_in2, byte_enable_in} = 4'hf;
    for (int i = 0; i < 2; i++) begin
      wr(0, 8'(8'h10 << i));
      seen = 2'h0;
      repeat (4) begin
        cyc(1);
        seen |= {pld_mcell_clk, pld_and_clk};
      end
      chk("clk block", seen, 8'(2'h2 >> i));
    end
    chk("pld in", {pld_ctrl0, pld_ctrl1, pld_ctrl2, pld_strobe,
                   pld_byte_en, |pld_addr_lo}, 8'h3f);
    wr(1, 8'h7d);
    cyc(1);
    chk("pmr2", power_ctrl_reg2, 8'h7d);
    chk("pld blk", {pld_ctrl0, pld_ctrl1, pld_ctrl2, pld_strobe,
                    pld_byte_en, |pld_addr_lo}, 8'h0);
    wr(1, 8'h00);
    {mcell_pr, mcell_re} = 16'h0102;
    cyc(2);
    chk("mcell", output_macrocell[1:0], 8'h1);
  endtask

  task automatic t_apd();
    int n;
    // Macrocell clock stays blocked from the block test on
    addr_strobe = 1'b1;
    cyc(40);
    chk("pd off", powerdown_flag, 8'h0);
    apd_enable = 1'b1;
    repeat (20) begin
      addr_strobe = !addr_strobe;
      cyc(2);
    end
    chk("pd pulse", powerdown_flag, 8'h0);
    for (int p = 1; p >= 0; p--) begin
      {strobe_polarity, addr_strobe} = {2{p[0]}};
      wait_on(powerdown_flag, 1'b1, n);
      chk("pd time", 8'(n >= 27 && n <= 33), 8'h1);
      // Ports and gated paths follow the flag one cycle later
      cyc(1);
      chk("pd ports", {data_oe_n, periph_oe_n, gpio_oe_n,
                       |pld_addr_lo, pld_ctrl0}, 8'h19);
      wr(0, 8'h00);
      chk("pd wr", power_ctrl_reg0, 8'h20);
      if (p == 1)
        addr_strobe = 1'b0;
      else
        select_n = 1'b0;
      cyc(2);
      chk("wake", powerdown_flag, 8'h0);
      select_n = 1'b1;
    end
    apd_enable = 1'b0;
  endtask

  task automatic t_flash();
    int n;
    lockout_voltage = 1'b1;
    flash_prog_start = 1'b1;
    cyc(1);
    flash_prog_start = 1'b0;
    cyc(1);
    chk("lockout", flash_busy, 8'h0);
    lockout_voltage = 1'b0;
    flash_prog_start = 1'b1;
    cyc(1);
    flash_prog_start = 1'b0;
    chk("prog", flash_busy, 8'h1);
    // Erase below is only taken once programming has returned to read
    flash_op_done = 1'b1;
    cyc(1);
    flash_op_done = 1'b0;
    wr(2, 8'h81);
    cyc(1);
    chk("mm bits", {peripheral_mode_bit, sram_code_bit}, 8'h3);
    flash_erase_start = 1'b1;
    cyc(1);
    flash_erase_start = 1'b0;
    cyc(1);
    chk("busy", flash_busy, 8'h1);
    warm_req = 1'b1;
    cyc(1);
    warm_req = 1'b0;
    wait_on(flash_abort, 1'b1, n);
    chk("abort time", 8'(n <= 4), 8'h1);
    cyc(1);
    chk("read mode", {flash_busy, flash_abort}, 8'h0);
    chk("pld warm", pld_out_valid, 8'h1);
    wait_on(device_in_reset, 1'b0, n);
    chk("mm reload", memory_map_reg, `PRC_MM_RST_VAL);
    chk("pmr0 warm", power_ctrl_reg0, 8'h20);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    int n;
    {core_clk, rst, select_n, addr_strobe, strobe_polarity} = 5'h0f;
    {gpio_drive_req, addr_out_req, data_drive_req, periph_drive_req} = 4'hf;
    {apd_enable, ctrl_in1, ctrl_in2, byte_enable_in, pmr0_wr,
     pmr2_wr, mmap_wr, lockout_voltage, flash_prog_start, flash_op_done,
     flash_erase_start, clk_run, warm_req} = '0;
    ctrl_in0 = 1'b1; // write strobe idle high, selects low
    {addr_lo_in, reg_wdata, mcell_d, mcell_re, mcell_pr} = '0;
    {fails, checks} = '0;
    cyc(3);
    chk("cfg early", {pld_out_valid, |output_macrocell}, 8'h0);
    cyc(2);
    rst = 1'b0;
    cyc(1);
    chk("mm reset", memory_map_reg, `PRC_MM_RST_VAL);
    chk("pmr reset", power_ctrl_reg0 | power_ctrl_reg2, 8'h0);
    chk("flash read", flash_busy, 8'h0);
    chk("oe reset", {gpio_oe_n, addr_out_oe_n, data_oe_n,
                     periph_oe_n}, 8'hf);
    wait_on(device_in_reset, 1'b0, n);
    cyc(2);
    chk("cfg loaded", pld_out_valid, 8'h1);
    chk("oe run", {gpio_oe_n, addr_out_oe_n, data_oe_n,
                   periph_oe_n}, 8'h0);
    t_select();
    t_block();
    t_apd();
    t_flash();
    summarize();
  end
endmodule
